/* src/frc_top.v */
// Fault response configuration block with APB registers
`timescale 1ns/1ps
`default_nettype none
`include "frc_consts.vh"

// Summary of operation
// [R1] Codes 0-3 latch lock fault, assert fault out, set one gate state.
// [R2] Codes 4-7 auto-clear lock fault after retry interval, same gate states.
// [R3] Auto modes count retries; beyond the limit the fault latches.
// [R4] Code 8 reports the lock but leaves the gate stage alone.
// [R5] Codes 9 to 15 ignore lock detection completely.
// [R6] Four-bit deglitch; zero means lock is recognised without filtering.
// [R7] Low supply threshold: 0 none, else 4.5 to 12.5 V steps.
// [R8] Undervoltage policy: 0 latches, 1 clears when supply is in bounds.
// [R9] High supply threshold: 0 none, else 20 to 35 V steps.
// [R10] Overvoltage policy: 0 latches, 1 clears when supply is in bounds.
// [R11] Retry limit: 0 unlimited, else 2,3,5,7,10,15,20 attempts.
// [R12] Latched fault holds until explicit clear or reset.
// [R13] Clear or reset returns the retry count to zero.
module frc_top #(
  parameter RETRY_CYCLES = `FRC_RETRY_NS / `FRC_CLK_NS,
  parameter DEG_UNIT     = `FRC_DEG_UNIT,
  parameter VM_W         = 12
) (
  // Clock, reset, enable
  input  wire            pclk,
  input  wire            presetn,
  input  wire            clk_en,
  // APB slave
  input  wire            psel,
  input  wire            penable,
  input  wire            pwrite,
  input  wire [11:0]     paddr,
  input  wire [31:0]     pwdata,
  output reg  [31:0]     prdata,
  output reg             pready,
  output reg             pslverr,
  // Fault sources (asynchronous)
  input  wire            ilimit_lock_in,
  input  wire [VM_W-1:0] supply_mv_div10,
  // Power stage and indication
  output reg  [2:0]      gate_state_ff,
  output reg             fault_out_n,
  output reg             irq_ff
);
  reg  [31:0] fault_policy_config_two;
  reg         lk_s1_ff, lk_s2_ff;
  reg  [VM_W-1:0] vm_s1_ff, vm_s2_ff;
  reg         lock_flt_ff, uv_flt_ff, ov_flt_ff, latched_ff;
  reg  [4:0]  retry_cnt_ff;
  reg  [31:0] wait_ff;
  reg  [`FRC_ST_W-1:0] status_ff, mask_ff;
  reg         lock_prev_ff;
  wire        lock_det;
  wire [3:0]  mode;
  wire        auto_mode, latch_mode, act_mode;
  wire        uv_now, ov_now;
  wire        wr, rd, clr;
  wire [4:0]  limit;
  wire        lock_rise;
  wire [`FRC_ST_W-1:0] ev;
  reg  [31:0] nxt_rdata;
  reg         nxt_err;

  // Supply levels are in units of 10 mV; 0 disables the check
  function [VM_W-1:0] low_thr;
    input [2:0] c;
    case (c)
      3'h1:    low_thr = 12'h1c2;
      3'h2:    low_thr = 12'h1f4;
      3'h3:    low_thr = 12'h226;
      3'h4:    low_thr = 12'h258;
      3'h5:    low_thr = 12'h2ee;
      3'h6:    low_thr = 12'h3e8;
      3'h7:    low_thr = 12'h4e2;
      default: low_thr = 12'h000;
    endcase
  endfunction

  function [VM_W-1:0] high_thr;
    input [2:0] c;
    case (c)
      3'h1:    high_thr = 12'h7d0;
      3'h2:    high_thr = 12'h8ca;
      3'h3:    high_thr = 12'h9c4;
      3'h4:    high_thr = 12'habe;
      3'h5:    high_thr = 12'hbb8;
      3'h6:    high_thr = 12'hcb2;
      3'h7:    high_thr = 12'hdac;
      default: high_thr = 12'h000;
    endcase
  endfunction

  function [4:0] retry_max;
    input [2:0] c;
    case (c)
      3'h1:    retry_max = 5'h02;
      3'h2:    retry_max = 5'h03;
      3'h3:    retry_max = 5'h05;
      3'h4:    retry_max = 5'h07;
      3'h5:    retry_max = 5'h0a;
      3'h6:    retry_max = 5'h0f;
      3'h7:    retry_max = 5'h14;
      default: retry_max = 5'h00;
    endcase
  endfunction

  // Gate reaction follows the low two bits of codes 0-7
  function [2:0] gate_of;
    input [1:0] m;
    case (m)
      2'h0:    gate_of = `FRC_GATE_TRI;
      2'h1:    gate_of = `FRC_GATE_RECIRC;
      2'h2:    gate_of = `FRC_GATE_HS_BRAKE;
      default: gate_of = `FRC_GATE_LS_BRAKE;
    endcase
  endfunction

  assign mode       = fault_policy_config_two[`FRC_MODE_HI:`FRC_MODE_LO];
  assign latch_mode = (mode < `FRC_MODE_AUTO_LO); // see [R1]
  assign auto_mode  = !latch_mode && (mode < `FRC_MODE_REPORT); // see [R2]
  assign act_mode   = (mode < `FRC_MODE_OFF_LO); // see [R5]
  assign limit = retry_max(fault_policy_config_two[`FRC_RTY_HI:`FRC_RTY_LO]);

  assign wr  = psel && penable && pwrite && clk_en;
  assign rd  = psel && penable && !pwrite && clk_en;
  assign clr = wr && (paddr == `FRC_ADDR_CTRL) && pwdata[`FRC_CTRL_CLEAR];

  // Pin inputs cross in through two flops before anything reads them
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lk_s1_ff <= 1'b0;
      lk_s2_ff <= 1'b0;
      vm_s1_ff <= {VM_W{1'b0}};
      vm_s2_ff <= {VM_W{1'b0}};
    end
    else if (clk_en)
    begin
      lk_s1_ff <= ilimit_lock_in;
      lk_s2_ff <= lk_s1_ff;
      vm_s1_ff <= supply_mv_div10;
      vm_s2_ff <= vm_s1_ff;
    end
  end

  // Bus width word may tear across bits; levels drift slowly so it is benign
  frc_deglitch #(
    .UNIT_W (8)
  ) u_deg (
    .pclk        (pclk),
    .presetn     (presetn),
    .clk_en      (clk_en),
    .deg_sel     (fault_policy_config_two[`FRC_DEG_HI:`FRC_DEG_LO]),
    .unit_cycles (DEG_UNIT[7:0]),
    .raw_in      (lk_s2_ff && act_mode), // see [R5]
    .filt_ff     (lock_det)
  );

  assign uv_now = (fault_policy_config_two[`FRC_UVT_HI:`FRC_UVT_LO] != 3'h0)
    && (vm_s2_ff < low_thr(
        fault_policy_config_two[`FRC_UVT_HI:`FRC_UVT_LO])); // see [R7]
  assign ov_now = (fault_policy_config_two[`FRC_OVT_HI:`FRC_OVT_LO] != 3'h0)
    && (vm_s2_ff > high_thr(
        fault_policy_config_two[`FRC_OVT_HI:`FRC_OVT_LO])); // see [R9]
  assign lock_rise = lock_det && !lock_prev_ff;

  // Lock fault, retry sequencing and supply faults
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lock_flt_ff  <= 1'b0;
      latched_ff   <= 1'b0;
      retry_cnt_ff <= 5'h00;
      wait_ff      <= 32'h0000_0000;
      uv_flt_ff    <= 1'b0;
      ov_flt_ff    <= 1'b0;
      lock_prev_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      lock_prev_ff <= lock_det;
      if (clr)
      begin
        lock_flt_ff  <= 1'b0; // see [R12]
        latched_ff   <= 1'b0;
        retry_cnt_ff <= 5'h00; // see [R13]
        wait_ff      <= 32'h0000_0000;
      end
      else if (!lock_flt_ff)
      begin
        if (lock_det && (latch_mode || auto_mode))
        begin
          lock_flt_ff <= 1'b1; // see [R1]
          latched_ff  <= latch_mode;
          wait_ff     <= 32'h0000_0000;
        end
      end
      else if (!latched_ff && auto_mode)
      begin
        if (wait_ff >= RETRY_CYCLES - 1)
        begin
          wait_ff <= 32'h0000_0000;
          // A retry only counts when the limit still allows one
          if (limit != 5'h00 && retry_cnt_ff >= limit)
            latched_ff <= 1'b1; // see [R3]
          else
          begin
            lock_flt_ff <= 1'b0; // see [R2]
            if (retry_cnt_ff != 5'h1f)
              retry_cnt_ff <= retry_cnt_ff + 5'h01; // see [R11]
          end
        end
        else
          wait_ff <= wait_ff + 32'h0000_0001;
      end

      if (uv_now)
        uv_flt_ff <= 1'b1;
      else if (fault_policy_config_two[`FRC_UVP_BIT] || clr)
        uv_flt_ff <= 1'b0; // see [R8]
      if (ov_now)
        ov_flt_ff <= 1'b1;
      else if (fault_policy_config_two[`FRC_OVP_BIT] || clr)
        ov_flt_ff <= 1'b0; // see [R10]
    end
  end

  // Outputs to the power stage and indication pin
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gate_state_ff <= `FRC_GATE_RUN;
      fault_out_n   <= 1'b1;
    end
    else if (clk_en)
    begin
      if (lock_flt_ff)
        gate_state_ff <= gate_of(mode[1:0]); // see [R1] see [R3]
      else if (uv_flt_ff || ov_flt_ff)
        gate_state_ff <= `FRC_GATE_TRI;
      else
        gate_state_ff <= `FRC_GATE_RUN; // see [R4]
      fault_out_n <= !(lock_flt_ff || uv_flt_ff || ov_flt_ff
                      || (lock_det && mode == `FRC_MODE_REPORT)); // see [R4]
    end
  end

  assign ev = {(lock_flt_ff && latched_ff && auto_mode), ov_now, uv_now,
               lock_rise};

  // APB registers, status read-to-clear with set winning
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fault_policy_config_two <= `FRC_CFG_RST;
      status_ff <= {`FRC_ST_W{1'b0}};
      mask_ff   <= {`FRC_ST_W{1'b0}};
      prdata    <= 32'h0000_0000;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      irq_ff    <= 1'b0;
    end
    else if (clk_en)
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && nxt_err;
      prdata  <= (psel && !penable && !pwrite) ? nxt_rdata : prdata;
      if (wr && paddr == `FRC_ADDR_CFG)
        fault_policy_config_two <= pwdata & `FRC_CFG_WMASK;
      if (wr && paddr == `FRC_ADDR_MASK)
        mask_ff <= pwdata[`FRC_ST_W-1:0];
      // Clear only the bits the read returned; an event at setup survives
      if (rd && pready && paddr == `FRC_ADDR_STATUS)
        status_ff <= (status_ff & ~prdata[`FRC_ST_W-1:0]) | ev;
      else
        status_ff <= status_ff | ev;
      irq_ff <= |(status_ff & mask_ff);
    end
  end

  always @*
  begin
    nxt_err   = 1'b0;
    nxt_rdata = 32'h0000_0000;
    case (paddr)
      `FRC_ADDR_CFG:    nxt_rdata = fault_policy_config_two;
      `FRC_ADDR_CTRL:   nxt_rdata = 32'h0000_0000;
      `FRC_ADDR_STATUS: nxt_rdata = {28'h0000000, status_ff};
      `FRC_ADDR_MASK:   nxt_rdata = {28'h0000000, mask_ff};
      `FRC_ADDR_STATE:  nxt_rdata = {16'h0000, retry_cnt_ff, 4'h0, gate_state_ff,
                                     latched_ff, ov_flt_ff, uv_flt_ff,
                                     lock_flt_ff};
      default:          nxt_err = 1'b1;
    endcase
  end
endmodule // frc_top
`default_nettype wire

/* common/frc_consts.vh */
// Constants for the fault response configuration block
`ifndef FRC_CONSTS_VH
`define FRC_CONSTS_VH

// Register byte addresses
`define FRC_ADDR_CFG      12'h000
`define FRC_ADDR_CTRL     12'h004
`define FRC_ADDR_STATUS   12'h008
`define FRC_ADDR_MASK     12'h00c
`define FRC_ADDR_STATE    12'h010

// Configuration field positions
`define FRC_MODE_HI       18
`define FRC_MODE_LO       15
`define FRC_DEG_HI        14
`define FRC_DEG_LO        11
`define FRC_UVT_HI        10
`define FRC_UVT_LO        8
`define FRC_UVP_BIT       7
`define FRC_OVT_HI        6
`define FRC_OVT_LO        4
`define FRC_OVP_BIT       3
`define FRC_RTY_HI        2
`define FRC_RTY_LO        0
`define FRC_CFG_RST       32'h0000_0000
`define FRC_CFG_WMASK     32'h0007_ffff

// Lock response codes
`define FRC_MODE_AUTO_LO  4'h4
`define FRC_MODE_REPORT   4'h8
`define FRC_MODE_OFF_LO   4'h9

// Gate stage reactions
`define FRC_GATE_RUN      3'h0
`define FRC_GATE_TRI      3'h1
`define FRC_GATE_RECIRC   3'h2
`define FRC_GATE_HS_BRAKE 3'h3
`define FRC_GATE_LS_BRAKE 3'h4

// Control and status bits
`define FRC_CTRL_CLEAR    0
`define FRC_ST_LOCK       0
`define FRC_ST_UV         1
`define FRC_ST_OV         2
`define FRC_ST_RTY_LATCH  3
`define FRC_ST_W          4

// Timing
`define FRC_RETRY_NS      5000000
`define FRC_CLK_NS        10
`define FRC_DEG_UNIT      8'h10

`endif

/* src/frc_deglitch.v */
// Deglitch filter for the current-limit lock indication
`timescale 1ns/1ps
`default_nettype none
module frc_deglitch #(
  parameter UNIT_W = 8
) (
  // Clock and reset
  input  wire              pclk,
  input  wire              presetn,
  input  wire              clk_en,
  // Control
  input  wire [3:0]        deg_sel,
  input  wire [UNIT_W-1:0] unit_cycles,
  // Data
  input  wire              raw_in,
  output reg               filt_ff
);
  localparam CW = UNIT_W + 4;
  reg  [CW-1:0] cnt_ff;
  wire [CW-1:0] limit;

  assign limit = deg_sel * unit_cycles;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_ff  <= {CW{1'b0}};
      filt_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!raw_in)
      begin
        cnt_ff  <= {CW{1'b0}};
        filt_ff <= 1'b0;
      end
      else if (cnt_ff >= limit)
        filt_ff <= 1'b1; // Setting zero passes the level straight on; see [R6]
      else
        cnt_ff <= cnt_ff + {{(CW-1){1'b0}}, 1'b1};
    end
  end
endmodule // frc_deglitch
`default_nettype wire

/* tb/frc_top_asserts.sv */
// Port assertions for the fault response block
`timescale 1ns/1ps
`default_nettype none
`include "frc_consts.vh"
module frc_top_asserts #(
  parameter VM_W = 12
) (
  // Clock and reset
  input wire logic            pclk,
  input wire logic            presetn,
  input wire logic            clk_en,
  // Register bus
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pwrite,
  input wire logic [11:0]     paddr,
  input wire logic [31:0]     pwdata,
  input wire logic [31:0]     prdata,
  input wire logic            pready,
  input wire logic            pslverr,
  // Fault side
  input wire logic            ilimit_lock_in,
  input wire logic [VM_W-1:0] supply_mv_div10,
  input wire logic [2:0]      gate_state_ff,
  input wire logic            fault_out_n,
  input wire logic            irq_ff
);
  logic [18:0] cfg_ff;
  logic [1:0]  since_clr_ff;
  wire         wr_acc = psel && penable && pready && pwrite && clk_en;
  wire         clr_w = wr_acc && paddr == `FRC_ADDR_CTRL && pwdata[0];
  wire         no_vm = cfg_ff[10:8] == 3'h0 && cfg_ff[6:4] == 3'h0;
  wire  [3:0]  mode = cfg_ff[18:15];
  // Shadow of the config word; output lags a clear by a few flops
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      cfg_ff <= 19'h0;
      since_clr_ff <= 2'h0;
    end
    else
    begin
      if (wr_acc && paddr == `FRC_ADDR_CFG)
        cfg_ff <= pwdata[18:0];
      if (clr_w)
        since_clr_ff <= 2'h0;
      else if (since_clr_ff != 2'h3)
        since_clr_ff <= since_clr_ff + 2'h1;
    end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable && clk_en;
  endsequence
  sequence clear_s;
    clr_w && !ilimit_lock_in && no_vm;
  endsequence
  apb_answer_a: assert property (setup_s |=> pready)
    else $error("no answer after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held high");
  unmap_read_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  cfg_read_a: assert property (
    pready && !pwrite && paddr == `FRC_ADDR_CFG |-> prdata == {13'h0, cfg_ff})
    else $error("config read differs");
  gate_fault_a: assert property (
    gate_state_ff != 3'h0 |-> !fault_out_n) else $error("gate without fault");
  report_gate_a: assert property (mode == 4'h8 && no_vm &&
    gate_state_ff == 3'h0 |=> gate_state_ff == 3'h0)
    else $error("report mode moved gate");
  lock_off_a: assert property (
    mode >= 4'h9 && no_vm && fault_out_n |=> fault_out_n)
    else $error("fault while detection off");
  latch_hold_a: assert property (mode < 4'h4 && no_vm &&
    !fault_out_n && since_clr_ff == 2'h3 && !clr_w |=> !fault_out_n)
    else $error("latched fault dropped");
  clear_free_a: assert property (
    clear_s |-> ##[1:4] fault_out_n) else $error("clear did not release");
endmodule // frc_top_asserts
bind frc_top frc_top_asserts #(.VM_W(VM_W)) frc_top_asserts_i (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ilimit_lock_in(ilimit_lock_in), .supply_mv_div10(supply_mv_div10),
  .gate_state_ff(gate_state_ff), .fault_out_n(fault_out_n),
  .irq_ff(irq_ff)
);
`default_nettype wire

/* tb/frc_stage_model.sv */
// Power stage sense lines feeding the block
`timescale 1ns/1ps
`default_nettype none
module frc_stage_model (
  // Clock
  input  wire logic        pclk,
  // Bench commands
  input  wire logic        lock_cmd,
  input  wire logic [11:0] vm_cmd,
  // Sense lines
  output var logic         lock_line,
  output var logic [11:0]  vm_line
);
  initial lock_line = 1'b0;
  initial vm_line = 12'h5dc;
  // Lines move just after an edge, never at the sampling instant
  always @(posedge pclk)
  begin
    lock_line <= lock_cmd;
    vm_line <= vm_cmd;
  end
endmodule // frc_stage_model
`default_nettype wire

/* tb/test_frc_top.sv */
// Self-checking bench for the fault response block
`timescale 1ns/1ps
`default_nettype none
`include "frc_consts.vh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
  num_errors++; $display("mismatch %0t %h %h", $time, g, e); end end
module test_frc_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        lock_cmd, lock_line, fault_out_n, irq_ff, rerr, clk_en;
  logic [11:0] paddr, vm_cmd, vm_line, thr;
  logic [31:0] pwdata, prdata, rdat, d;
  logic [2:0]  gate_state_ff;
  int          num_errors, total_checks, cyc, m, k, p;
  int          lim[8] = '{0, 2, 3, 5, 7, 10, 15, 20};
  int          vlo[8] = '{0, 450, 500, 550, 600, 750, 1000, 1250};
  int          vhi[8] = '{0, 2000, 2250, 2500, 2750, 3000, 3250, 3500};
  frc_top #(.RETRY_CYCLES(20)) frc_top_i (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ilimit_lock_in(lock_line), .supply_mv_div10(vm_line),
    .gate_state_ff(gate_state_ff), .fault_out_n(fault_out_n),
    .irq_ff(irq_ff)
  );
  frc_stage_model frc_stage_model_i (
    .pclk(pclk), .lock_cmd(lock_cmd), .vm_cmd(vm_cmd),
    .lock_line(lock_line), .vm_line(vm_line)
  );
  task test_done;
    if (num_errors == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] x);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= x;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task clr;
    apb(1'b1, `FRC_ADDR_CTRL, 32'h1);
    wt(6);
  endtask
  function logic [2:0] gexp(input int mm);
    return mm < 8 ? 3'(mm % 4 + 1) : 3'h0;
  endfunction
  function logic [31:0] cfg(input int mm, lo, up, hi, op, rt);
    return {13'h0, 4'(mm), 4'h0, 3'(lo), 1'(up), 3'(hi), 1'(op), 3'(rt)};
  endfunction
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Bounds a hang anywhere in the sequence
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      test_done();
    end
  end
  initial
  begin
    {psel, penable, pwrite, lock_cmd, presetn} = 5'h0;
    clk_en = 1'b1;
    paddr = 12'h0;
    pwdata = 32'h0;
    vm_cmd = 12'h5dc;
    k = $urandom(32'h6713);
    wt(12);
    presetn <= 1'b1;
    apb(1'b0, `FRC_ADDR_CFG, 32'h0);
    `CHK(rdat, `FRC_CFG_RST)
    apb(1'b0, 12'h020, 32'h0);
    `CHK(rerr, 1'b1)
    `CHK(rdat, 32'h0)
    repeat (4)
    begin
      d = $urandom;
      apb(1'b1, `FRC_ADDR_CFG, d);
      apb(1'b0, `FRC_ADDR_CFG, 32'h0);
      `CHK(rdat, d & `FRC_CFG_WMASK)
    end
    for (m = 0; m < 16; m++)
    begin
      apb(1'b1, `FRC_ADDR_CFG, cfg(m, 0, 0, 0, 0, 0));
      apb(1'b1, `FRC_ADDR_MASK, {31'h0, ~m[0]});
      clr();
      apb(1'b0, `FRC_ADDR_STATUS, 32'h0);
      lock_cmd <= 1'b1;
      wt(12);
      `CHK(gate_state_ff, gexp(m))
      `CHK(fault_out_n, 1'(m > 8))
      `CHK(irq_ff, 1'(m < 9 && !m[0]))
      apb(1'b0, `FRC_ADDR_STATUS, 32'h0);
      `CHK(rdat[0], 1'(m < 9))
      lock_cmd <= 1'b0;
      wt(40);
      `CHK(gate_state_ff, m < 4 ? gexp(m) : 3'h0)
      `CHK(fault_out_n, 1'(m > 3))
      `CHK(irq_ff, 1'b0)
    end
    for (k = 0; k < 8; k++)
    begin
      apb(1'b1, `FRC_ADDR_CFG, cfg(4, 0, 0, 0, 0, k));
      clr();
      lock_cmd <= 1'b1;
      wt(700);
      apb(1'b0, `FRC_ADDR_STATE, 32'h0);
      `CHK(rdat[3], 1'(k != 0))
      if (k != 0)
        `CHK(rdat[15:11], 5'(lim[k]))
      lock_cmd <= 1'b0;
      wt(60);
      `CHK(gate_state_ff, k != 0 ? 3'h1 : 3'h0)
      clr();
      apb(1'b0, `FRC_ADDR_STATE, 32'h0);
      `CHK(rdat[15:11], 5'h0)
    end
    for (m = 0; m < 8; m++)
    begin
      k = $urandom_range(7, 1);
      p = $urandom_range(1, 0);
      thr = 12'(m[0] ? vlo[k] : vhi[k]);
      vm_cmd <= thr;
      if (m[0])
        d = cfg(0, k, p, 0, 0, 0);
      else
        d = cfg(0, 0, 0, k, p, 0);
      apb(1'b1, `FRC_ADDR_CFG, d);
      clr();
      `CHK(fault_out_n, 1'b1)
      vm_cmd <= m[0] ? thr - 12'h1 : thr + 12'h1;
      wt(10);
      `CHK(gate_state_ff, 3'h1)
      vm_cmd <= 12'($urandom_range(1800, 1300));
      wt(10);
      `CHK(fault_out_n, 1'(p))
      clr();
    end
    apb(1'b1, `FRC_ADDR_CFG, 32'h0);
    vm_cmd <= 12'h0;
    wt(10);
    `CHK(fault_out_n, 1'b1)
    // Sixteen-cycle deglitch must swallow a ten-cycle lock pulse
    apb(1'b1, `FRC_ADDR_CFG, 32'h0000_0800);
    lock_cmd <= 1'b1;
    wt(10);
    lock_cmd <= 1'b0;
    wt(10);
    `CHK(fault_out_n, 1'b1)
    // Enable low freezes the whole pipeline, so no fault may appear
    clk_en <= 1'b0;
    lock_cmd <= 1'b1;
    wt(40);
    `CHK(fault_out_n, 1'b1)
    clk_en <= 1'b1;
    wt(30);
    `CHK(fault_out_n, 1'b0)
    test_done();
  end
endmodule // test_frc_top
`default_nettype wire
